// ==== logic/pdm_ctrl.v ====
// power-down mode controller with axi4-lite register access
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.vh"

module pdm_ctrl (
	input  wire                  i_clk_sys,       // system clock, 100 MHz
	input  wire                  i_srst,          // synchronous reset, active high
	input  wire [7:0]            s_axi_awaddr,    // write address
	input  wire                  s_axi_awvalid,   // write address valid
	output wire                  s_axi_awready,   // write address ready
	input  wire [31:0]           s_axi_wdata,     // write data
	input  wire [3:0]            s_axi_wstrb,     // write byte strobes
	input  wire                  s_axi_wvalid,    // write data valid
	output wire                  s_axi_wready,    // write data ready
	output reg  [1:0]            s_axi_bresp,     // write response
	output reg                   s_axi_bvalid,    // write response valid
	input  wire                  s_axi_bready,    // write response ready
	input  wire [7:0]            s_axi_araddr,    // read address
	input  wire                  s_axi_arvalid,   // read address valid
	output wire                  s_axi_arready,   // read address ready
	output reg  [31:0]           s_axi_rdata,     // read data
	output reg  [1:0]            s_axi_rresp,     // read response
	output reg                   s_axi_rvalid,    // read data valid
	input  wire                  s_axi_rready,    // read data ready
	input  wire [`PDM_IRQ_W-1:0] i_irq_pend,      // pending interrupt lines, level
	input  wire                  i_pll_locked,    // pll reports lock
	input  wire                  i_emu_attached,  // emulator attached and out of reset
	output reg                   o_cpu_clk_en,    // cpu clock gate enable
	output reg                   o_irq_clk_en,    // interrupt logic clock enable
	output reg                   o_dma_clk_en,    // dma engine and peripheral clock enable
	output reg                   o_pll_out_stop,  // stop pll output clock
	output reg                   o_pll_in_stop,   // stop pll input clock
	output reg                   o_io_freeze,     // hold all functional outputs
	output reg                   o_emu_spin_idle, // emulator commands spin idle
	output reg                   o_wake_service,  // pulse: run service routine then resume
	output reg                   o_wake_resume,   // pulse: resume at sleep point
	output reg  [2:0]            o_pd_state       // controller state
);
	// register selects, shared by the read and write decoders
	localparam [1:0] REG_CTRL = 2'h0;
	localparam [1:0] REG_IEN  = 2'h1;
	localparam [1:0] REG_STAT = 2'h2;
	localparam [1:0] REG_NONE = 2'h3;

	// one address map for reads and writes
	function [1:0] pdm_decode;
		input [7:0] addr;
		begin
			if (addr == `PDM_OFS_CTRL_STATUS)
				pdm_decode = REG_CTRL;
			else if (addr == `PDM_OFS_IRQ_ENABLE)
				pdm_decode = REG_IEN;
			else if (addr == `PDM_OFS_PD_STATUS)
				pdm_decode = REG_STAT;
			else
				pdm_decode = REG_NONE;
		end
	endfunction

	reg [`PDM_SEL_W-1:0] sleep_select_field;
	reg                  global_irq_enable;
	reg [`PDM_IRQ_W-1:0] irq_enable_reg;
	reg                  reserved_seen;
	reg                  wake_any;
	reg [2:0]            state;
	reg [2:0]            next_state;

	reg                  aw_held;
	reg [7:0]            aw_addr;
	reg                  w_held;
	reg [31:0]           w_data;
	reg [3:0]            w_strb;

	wire                 frozen;
	wire                 wr_go;
	wire [1:0]           wr_sel;
	wire [1:0]           rd_sel;
	wire                 sel_load;
	wire                 fire;
	wire [5:0]           fire_code;
	wire                 irq_any;
	wire                 irq_enabled;
	wire                 nonmaskable_irq_enable;
	wire [31:0]          ctrl_word;
	wire [31:0]          stat_word;

	// a halted chip keeps its control registers and power-down outputs as they were when its clock stopped; the bus path still runs
	assign frozen = (state == `PDM_ST_PLL_OUT) || (state == `PDM_ST_PLL_IN);

	// ---- axi4-lite write path: address and data taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_go         = aw_held && w_held && !s_axi_bvalid;
	assign wr_sel        = pdm_decode(aw_addr);

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			aw_held      <= 1'b0;
			aw_addr      <= 8'h00;
			w_held       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PDM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel == REG_NONE) ? `PDM_RESP_SLVERR : `PDM_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// a halted chip stores nothing; the bus still answers so a master never hangs
	assign sel_load = wr_go && (wr_sel == REG_CTRL) && w_strb[1] && !frozen;

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			sleep_select_field <= `PDM_RST_SEL;
			global_irq_enable  <= 1'b0;
			irq_enable_reg     <= `PDM_RST_IRQ_EN;
		end else if (wr_go && !frozen) begin
			if (wr_sel == REG_CTRL) begin
				if (w_strb[1])
					sleep_select_field <= w_data[`PDM_SEL_HI:`PDM_SEL_LO];
				if (w_strb[0])
					global_irq_enable <= w_data[`PDM_GLB_EN_BIT];
			end else if (wr_sel == REG_IEN) begin
				if (w_strb[0])
					irq_enable_reg[7:0] <= w_data[7:0];
				if (w_strb[1])
					irq_enable_reg[15:8] <= w_data[15:8];
			end
		end
	end

	assign nonmaskable_irq_enable = irq_enable_reg[`PDM_NMI_EN_BIT];

	// the written code travels a fixed pipe before it acts
	pdm_entry_pipe u_entry (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_load    (sel_load),
		.i_code    (w_data[`PDM_SEL_HI:`PDM_SEL_LO]),
		.o_fire    (fire),
		.o_code    (fire_code)
	);

	// ---- axi4-lite read path
	assign rd_sel    = pdm_decode(s_axi_araddr);
	assign s_axi_arready = !s_axi_rvalid;
	assign ctrl_word = {16'h0000, sleep_select_field, 9'h000, global_irq_enable};
	assign stat_word = {24'h00_0000, i_pll_locked, i_emu_attached, wake_any, reserved_seen,
	                    1'b0, state};

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `PDM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `PDM_RESP_OKAY;
			if (rd_sel == REG_CTRL)
				s_axi_rdata <= ctrl_word;
			else if (rd_sel == REG_IEN)
				s_axi_rdata <= {16'h0000, irq_enable_reg};
			else if (rd_sel == REG_STAT)
				s_axi_rdata <= stat_word;
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `PDM_RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---- mode sequencing
	// interrupt lines are levels; a wake needs the line still pending at the edge
	assign irq_any     = |i_irq_pend;
	assign irq_enabled = |(i_irq_pend & irq_enable_reg);

	// a code that fires outside the run state is dropped; it acts only from run
	always @* begin
		next_state = state;
		case (state)
			`PDM_ST_LOCK: begin
				if (i_pll_locked)
					next_state = `PDM_ST_RUN;
			end
			`PDM_ST_RUN: begin
				if (fire && !i_emu_attached) begin
					case (fire_code)
						`PDM_CODE_SLEEP_EN:  next_state = `PDM_ST_SLEEP;
						`PDM_CODE_SLEEP_ANY: next_state = `PDM_ST_SLEEP;
						`PDM_CODE_PLL_OUT:   next_state = `PDM_ST_PLL_OUT;
						`PDM_CODE_PLL_IN:    next_state = `PDM_ST_PLL_IN;
						default:             next_state = `PDM_ST_RUN;
					endcase
				end
			end
			`PDM_ST_SLEEP: begin
				if (i_emu_attached || irq_enabled || (wake_any && irq_any))
					next_state = `PDM_ST_RUN;
			end
			// no interrupt leaves these, only the reset branch below
			`PDM_ST_PLL_OUT: next_state = `PDM_ST_PLL_OUT;
			`PDM_ST_PLL_IN:  next_state = `PDM_ST_PLL_IN;
			default:         next_state = `PDM_ST_LOCK;
		endcase
	end

	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			state         <= `PDM_ST_LOCK;
			wake_any      <= 1'b0;
			reserved_seen <= 1'b0;
		end else begin
			state <= next_state;
			if (fire && state == `PDM_ST_RUN) begin
				wake_any      <= (fire_code == `PDM_CODE_SLEEP_ANY);
				reserved_seen <= (fire_code != `PDM_CODE_NONE) &&
				                 (fire_code != `PDM_CODE_SLEEP_EN) &&
				                 (fire_code != `PDM_CODE_SLEEP_ANY) &&
				                 (fire_code != `PDM_CODE_PLL_OUT) &&
				                 (fire_code != `PDM_CODE_PLL_IN);
			end
		end
	end

	// ---- outputs, all from flops; in the pll-stop states none of them moves again
	always @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_cpu_clk_en    <= 1'b0;
			o_irq_clk_en    <= 1'b1;
			o_dma_clk_en    <= 1'b1;
			o_pll_out_stop  <= 1'b0;
			o_pll_in_stop   <= 1'b0;
			o_io_freeze     <= 1'b0;
			o_emu_spin_idle <= 1'b0;
			o_wake_service  <= 1'b0;
			o_wake_resume   <= 1'b0;
			o_pd_state      <= `PDM_ST_LOCK;
		end else if (!frozen) begin
			o_cpu_clk_en    <= (next_state == `PDM_ST_RUN);
			o_irq_clk_en    <= (next_state == `PDM_ST_RUN) || (next_state == `PDM_ST_SLEEP) ||
			                   (next_state == `PDM_ST_LOCK);
			o_dma_clk_en    <= (next_state == `PDM_ST_RUN) || (next_state == `PDM_ST_SLEEP) ||
			                   (next_state == `PDM_ST_LOCK);
			o_pll_out_stop  <= (next_state == `PDM_ST_PLL_OUT);
			o_pll_in_stop   <= (next_state == `PDM_ST_PLL_IN);
			o_io_freeze     <= (next_state == `PDM_ST_PLL_OUT) ||
			                   (next_state == `PDM_ST_PLL_IN);
			o_emu_spin_idle <= (next_state == `PDM_ST_PLL_OUT) ||
			                   (next_state == `PDM_ST_PLL_IN);
			o_pd_state      <= next_state;
			// the service routine runs only when its own gates are open
			o_wake_service  <= (state == `PDM_ST_SLEEP) && (next_state == `PDM_ST_RUN) &&
			                   irq_enabled && global_irq_enable &&
			                   nonmaskable_irq_enable;
			o_wake_resume   <= (state == `PDM_ST_SLEEP) && (next_state == `PDM_ST_RUN) &&
			                   !(irq_enabled && global_irq_enable &&
			                     nonmaskable_irq_enable);
		end
	end
endmodule

`default_nettype wire

// ==== logic/pdm_map.vh ====
// register offsets, field positions, mode codes and timing counts of the power-down controller
`ifndef PDM_MAP_VH
`define PDM_MAP_VH

// register byte offsets
`define PDM_OFS_CTRL_STATUS 8'h00
`define PDM_OFS_IRQ_ENABLE  8'h04
`define PDM_OFS_PD_STATUS   8'h08

// cpu_control_status_reg fields
`define PDM_GLB_EN_BIT      0
`define PDM_SEL_HI          15
`define PDM_SEL_LO          10
`define PDM_SEL_W           6

// irq_enable_reg fields
`define PDM_NMI_EN_BIT      1
`define PDM_IRQ_W           16

// sleep_select_field codes
`define PDM_CODE_NONE       6'h00
`define PDM_CODE_SLEEP_EN   6'h09
`define PDM_CODE_SLEEP_ANY  6'h11
`define PDM_CODE_PLL_OUT    6'h1A
`define PDM_CODE_PLL_IN     6'h1C

// reset values
`define PDM_RST_SEL         6'h00
`define PDM_RST_IRQ_EN      16'h0000

// cycles from the accepted write to the mode taking effect
`define PDM_ENTRY_DLY       9

// controller states
`define PDM_ST_LOCK         3'h0
`define PDM_ST_RUN          3'h1
`define PDM_ST_SLEEP        3'h2
`define PDM_ST_PLL_OUT      3'h3
`define PDM_ST_PLL_IN       3'h4

// axi responses
`define PDM_RESP_OKAY       2'h0
`define PDM_RESP_SLVERR     2'h2

`endif

// ==== logic/pdm_entry_pipe.v ====
// fixed-length delay line carrying a written sleep code to the point where it takes effect
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.vh"

module pdm_entry_pipe (
	input  wire       i_clk_sys, // system clock
	input  wire       i_srst,    // synchronous reset, active high
	input  wire       i_load,    // one-cycle pulse: a new code was written
	input  wire [5:0] i_code,    // written code
	output wire       o_fire,    // one-cycle pulse, code takes effect
	output wire [5:0] o_code     // code that takes effect
);
	reg [`PDM_ENTRY_DLY-1:0] vld;
	reg [5:0]                code_q [0:`PDM_ENTRY_DLY-1];

	genvar g;
	generate
		for (g = 0; g < `PDM_ENTRY_DLY; g = g + 1) begin : g_stage
			if (g == 0) begin : g_first
				always @(posedge i_clk_sys) begin
					if (i_srst) begin
						vld[0]    <= 1'b0;
						code_q[0] <= `PDM_CODE_NONE;
					end else begin
						vld[0]    <= i_load;
						code_q[0] <= i_code;
					end
				end
			end else begin : g_next
				always @(posedge i_clk_sys) begin
					if (i_srst) begin
						vld[g]    <= 1'b0;
						code_q[g] <= `PDM_CODE_NONE;
					end else begin
						vld[g]    <= vld[g-1];
						code_q[g] <= code_q[g-1];
					end
				end
			end
		end
	endgenerate

	assign o_fire = vld[`PDM_ENTRY_DLY-1];
	assign o_code = code_q[`PDM_ENTRY_DLY-1];
endmodule

`default_nettype wire

// ==== test/pdm_ctrl_properties.sv ====
// concurrent checks on the power-down controller ports
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_properties (
	input wire logic        i_clk_sys,       // clock
	input wire logic        i_srst,          // reset
	input wire logic [7:0]  s_axi_awaddr,    // write addr
	input wire logic        s_axi_awvalid,   // aw valid
	input wire logic        s_axi_awready,   // aw ready
	input wire logic [31:0] s_axi_wdata,     // write data
	input wire logic [3:0]  s_axi_wstrb,     // strobes
	input wire logic        s_axi_wvalid,    // w valid
	input wire logic        s_axi_wready,    // w ready
	input wire logic [15:0] i_irq_pend,      // pending lines
	input wire logic        i_pll_locked,    // lock
	input wire logic        i_emu_attached,  // emulator
	input wire logic        o_cpu_clk_en,    // cpu clock
	input wire logic        o_irq_clk_en,    // irq clock
	input wire logic        o_dma_clk_en,    // dma clock
	input wire logic        o_pll_out_stop,  // out stop
	input wire logic        o_pll_in_stop,   // in stop
	input wire logic        o_io_freeze,     // freeze
	input wire logic        o_emu_spin_idle, // spin idle
	input wire logic        o_wake_service,  // service pulse
	input wire logic        o_wake_resume,   // resume pulse
	input wire logic [2:0]  o_pd_state       // state
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	sequence s_out_stop_write;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00 &&
		s_axi_wstrb[1] && s_axi_wdata[15:10] == 6'h1A && o_pd_state == 3'h1 && !i_emu_attached;
	endsequence
	// store one edge after the take, then nine pipe cycles
	sequence s_run_then_stop;
		(o_pd_state == 3'h1) [*8] ##1 (o_pd_state == 3'h1) [*2] ##1 (o_pd_state == 3'h3);
	endsequence
	a_entry_delay: assert property (s_out_stop_write |=> s_run_then_stop) else $error("entry delay wrong");
	a_sleep_gate: assert property (o_pd_state == 3'h2 |-> !o_cpu_clk_en && o_irq_clk_en && o_dma_clk_en)
		else $error("light sleep clocks wrong");
	a_out_stop_outs: assert property (o_pd_state == 3'h3 |-> o_pll_out_stop && o_io_freeze && o_emu_spin_idle)
		else $error("pll output stop outputs wrong");
	a_in_stop_outs: assert property (o_pd_state == 3'h4 |-> o_pll_in_stop && o_io_freeze && o_emu_spin_idle)
		else $error("pll input stop outputs wrong");
	a_stop_held: assert property (o_pd_state >= 3'h3 |=> o_pd_state == $past(o_pd_state) &&
		$stable({o_cpu_clk_en, o_irq_clk_en, o_dma_clk_en})) else $error("stop state not held");
	a_wake_origin: assert property ((o_wake_service || o_wake_resume) |-> $past(o_pd_state) == 3'h2 &&
		o_pd_state == 3'h1 && o_cpu_clk_en && !(o_wake_service && o_wake_resume)) else $error("bad wake pulse");
	a_sleep_no_cause: assert property (o_pd_state == 3'h2 && i_irq_pend == 16'h0000 && !i_emu_attached
		|=> o_pd_state == 3'h2) else $error("woke without interrupt");
	a_emu_masks: assert property (o_pd_state == 3'h1 && i_emu_attached |=> o_pd_state == 3'h1)
		else $error("mode entered with emulator");
	a_lock_wait: assert property (o_pd_state == 3'h0 |=> o_pd_state == {2'b00, $past(i_pll_locked)} &&
		o_cpu_clk_en == $past(i_pll_locked)) else $error("lock wait wrong");
endmodule
bind pdm_ctrl pdm_ctrl_properties u_props (.i_clk_sys, .i_srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .i_irq_pend, .i_pll_locked, .i_emu_attached,
	.o_cpu_clk_en, .o_irq_clk_en, .o_dma_clk_en, .o_pll_out_stop, .o_pll_in_stop, .o_io_freeze,
	.o_emu_spin_idle, .o_wake_service, .o_wake_resume, .o_pd_state);
`default_nettype wire

// ==== test/pdm_pll_model.sv ====
// pll lock model: lock drops while its input clock is stopped
`timescale 1ns/1ps
`default_nettype none
module pdm_pll_model #(parameter int LOCK_CYC = 8) (
	input  wire logic i_clk_sys,     // clock
	input  wire logic i_pll_in_stop, // input clock stopped
	output wire logic o_pll_locked   // lock
);
	int   cnt    = 0;
	logic locked = 1'b0;
	assign o_pll_locked = locked;
	// relock takes a settle count, so wake from input stop is slower
	always @(posedge i_clk_sys) begin
		if (i_pll_in_stop) begin
			cnt <= 0;
			locked <= 1'b0;
		end else if (cnt < LOCK_CYC) begin
			cnt <= cnt + 1;
		end else begin
			locked <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== test/pdm_ctrl_bench.sv ====
// register-level bench of the power-down controller
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_bench;
	logic        i_clk_sys = 1'b0, i_srst = 1'b1, i_emu_attached = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [15:0] i_irq_pend = 16'h0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, i_pll_locked;
	wire         o_cpu_clk_en, o_irq_clk_en, o_dma_clk_en, o_pll_out_stop, o_pll_in_stop, o_io_freeze;
	wire         o_emu_spin_idle, o_wake_service, o_wake_resume;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [2:0]   o_pd_state;
	int          n_fail = 0, tests_run = 0, n_svc = 0, n_res = 0, e_svc = 0, e_res = 0;
	logic [15:0] c_ier [5] = '{16'h0000, 16'h000A, 16'h000A, 16'h0008, 16'h000A};
	logic [5:0]  c_code [5] = '{6'h11, 6'h09, 6'h09, 6'h09, 6'h11};
	logic [15:0] c_pend [5] = '{16'h0004, 16'h0008, 16'h0008, 16'h0008, 16'h0004};
	logic        c_glb_en [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic        c_svc [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

	pdm_ctrl u_dut (.i_clk_sys, .i_srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_irq_pend,
		.i_pll_locked, .i_emu_attached, .o_cpu_clk_en, .o_irq_clk_en, .o_dma_clk_en, .o_pll_out_stop,
		.o_pll_in_stop, .o_io_freeze, .o_emu_spin_idle, .o_wake_service, .o_wake_resume, .o_pd_state);
	pdm_pll_model #(.LOCK_CYC(8)) u_pll (.i_clk_sys, .i_pll_in_stop(o_pll_in_stop), .o_pll_locked(i_pll_locked));

	always #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		if (o_wake_service === 1'b1) n_svc++;
		if (o_wake_resume === 1'b1) n_res++;
	end

	task complete_run;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// every wait is bounded; running out ends the run as failed
	task tick(inout int k);
		@(posedge i_clk_sys);
		k++;
		if (k > 300) begin
			n_fail++;
			complete_run;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge i_clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			tick(k);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (s_axi_bvalid !== 1'b1) tick(k);
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge i_clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			tick(k);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_arvalid);
		while (s_axi_rvalid !== 1'b1) tick(k);
		check("rdata", s_axi_rdata, ed);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
		s_axi_rready <= 1'b0;
	endtask
	task wait_state(input logic [2:0] s);
		int k;
		k = 0;
		while (o_pd_state !== s) tick(k);
	endtask
	task reset_dut;
		@(posedge i_clk_sys);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		i_srst <= 1'b0;
	endtask

	initial begin
		repeat (10) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		wait_state(3'h1);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		rd(8'h0C, 32'h0, 2'h2);
		wr(8'h0C, 32'h1, 2'h2);
		for (int i = 0; i < 2; i++) begin
			wr(8'h00, {16'h0, (i == 0) ? 6'h00 : 6'h05, 10'h0}, 2'h0);
			repeat (14) @(posedge i_clk_sys);
			check("no mode", {29'h0, o_pd_state}, 32'h1);
			rd(8'h08, (i == 0) ? 32'h81 : 32'h91, 2'h0);
		end
		// wake table: line enabled or not, global and nonmaskable enables
		for (int i = 0; i < 5; i++) begin
			wr(8'h04, {16'h0, c_ier[i]}, 2'h0);
			wr(8'h00, {16'h0, c_code[i], 9'h0, c_glb_en[i]}, 2'h0);
			wait_state(3'h2);
			check("sleep clocks", {o_cpu_clk_en, o_irq_clk_en, o_dma_clk_en}, 32'h3);
			i_irq_pend <= c_pend[i];
			wait_state(3'h1);
			i_irq_pend <= 16'h0;
			e_svc += c_svc[i];
			e_res += !c_svc[i];
			@(posedge i_clk_sys);
			check("service", n_svc, e_svc);
			check("resume", n_res, e_res);
		end
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h00, {16'h0, 6'h09, 10'h0}, 2'h0);
		wait_state(3'h2);
		i_irq_pend <= 16'h0004;
		repeat (6) @(posedge i_clk_sys);
		check("disabled line", {29'h0, o_pd_state}, 32'h2);
		wr(8'h04, 32'h0004, 2'h0);
		wait_state(3'h1);
		i_irq_pend <= 16'h0;
		i_emu_attached <= 1'b1;
		wr(8'h00, {16'h0, 6'h1A, 10'h0}, 2'h0);
		repeat (14) @(posedge i_clk_sys);
		check("emulator mask", {29'h0, o_pd_state}, 32'h1);
		i_emu_attached <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		wr(8'h00, {16'h0, 6'h1A, 10'h0}, 2'h0);
		wait_state(3'h3);
		check("out stop", {o_pll_out_stop, o_pll_in_stop, o_io_freeze, o_emu_spin_idle}, 32'hB);
		i_irq_pend <= 16'hFFFF;
		wr(8'h00, 32'h0, 2'h0);
		rd(8'h00, {16'h0, 6'h1A, 10'h0}, 2'h0);
		repeat (10) @(posedge i_clk_sys);
		check("no irq exit", {29'h0, o_pd_state}, 32'h3);
		i_irq_pend <= 16'h0;
		reset_dut;
		wait_state(3'h1);
		check("cpu clock back", {31'h0, o_cpu_clk_en}, 32'h1);
		rd(8'h00, 32'h0, 2'h0);
		wr(8'h00, {16'h0, 6'h1C, 10'h0}, 2'h0);
		wait_state(3'h4);
		check("in stop", {o_pll_out_stop, o_pll_in_stop, o_io_freeze, o_emu_spin_idle}, 32'h7);
		reset_dut;
		repeat (2) @(posedge i_clk_sys);
		check("relock wait", {28'h0, o_pd_state, o_cpu_clk_en}, 32'h0);
		wait_state(3'h1);
		check("relocked", {31'h0, o_cpu_clk_en}, 32'h1);
		complete_run;
	end
endmodule
`default_nettype wire
